// ==== sfpi_defines.vh ====
// constants for the serial flash pin interface block
`ifndef SFPI_DEFINES_VH
`define SFPI_DEFINES_VH

// clock rate and synchroniser depth
`define SFPI_CLK_HZ 50000000
`define SFPI_SYNC_STAGES 2

// byte framing
`define SFPI_BYTE_BITS 8
`define SFPI_ADDR_BYTES 3
`define SFPI_ADDR_BITS 24

// command opcodes, values arbitrary
`define SFPI_OP_READ 8'h11
`define SFPI_OP_PROGRAM 8'h22
`define SFPI_OP_ERASE 8'h33
`define SFPI_OP_MAP_WRITE 8'h44
`define SFPI_OP_MAP_ERASE 8'h55
`define SFPI_OP_PROT_ENABLE 8'h66
`define SFPI_OP_PROT_DISABLE 8'h77
`define SFPI_OP_LOCK 8'h88

// sector protection map
`define SFPI_SECTORS 8
`define SFPI_SECTOR_MSB 23
`define SFPI_SECTOR_LSB 21
`define SFPI_MAP_RESET 8'h00

// receive fifo
`define SFPI_FIFO_DEPTH 16
`define SFPI_FIFO_WIDTH 8

// frame states
`define SFPI_ST_IDLE 3'h0
`define SFPI_ST_OPCODE 3'h1
`define SFPI_ST_ADDR 3'h2
`define SFPI_ST_DATA 3'h3
`define SFPI_ST_DISCARD 3'h4

`endif

// ==== sfpi_device.v ====
// serial flash pin interface, device side
// Notes on behaviour
// RULE_01 - chip select high: standby, output tri-stated
// RULE_02 - deselected: serial input ignored entirely
// RULE_03 - operations open/close on chip select edges
// RULE_04 - standby waits for self-timed operation end
// RULE_05 - input sampled on serial clock rising edge
// RULE_06 - output changes on serial clock falling edge
// RULE_07 - write-protect low guards all mapped sectors
// RULE_08 - write-protect low freezes the protection map
// RULE_09 - program/erase under write-protect silently discarded
// RULE_10 - enable and lock commands accepted under protect
// RULE_11 - unconnected write-protect reads as high
// RULE_12 - reset pin low aborts and idles
// RULE_13 - reset held while pin stays low
// RULE_14 - internal power-on reset, pin unconstrained
// RULE_15 - host should drive unused reset high
// RULE_16 - opcode byte then address after select
// RULE_17 - all bytes most significant bit first
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_defines.vh"
module sfpi_device #(
  parameter SECTORS = `SFPI_SECTORS,
  parameter FIFO_DEPTH = `SFPI_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire sys_clk,
  input wire nrst,
  input wire csN,
  input wire sck,
  input wire si,
  output reg soOut,
  output reg soOe,
  input wire wpN,
  input wire wpNConnected,
  input wire resetPinN,
  input wire coreBusy,
  output reg standby,
  output reg cmdValid,
  output reg [7:0] cmdOpcode,
  output reg [`SFPI_ADDR_BITS-1:0] cmdAddr,
  output reg cmdDiscarded,
  output reg lockReq,
  output reg protEnabled,
  output reg [SECTORS-1:0] protMap,
  input wire [7:0] txData,
  output reg txTaken,
  output wire rxValid,
  input wire rxReady,
  output wire [7:0] rxData,
  output reg rxOverrun
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

  reg [1:0] csSync_reg;
  reg [1:0] sckSync_reg;
  reg [1:0] siSync_reg;
  reg [1:0] wpSync_reg;
  reg [1:0] rstSync_reg;
  reg sckPrev_reg;
  reg csPrev_reg;
  wire csHigh;
  wire sckRise;
  wire sckFall;
  wire csFall;
  wire siBit;
  wire wpLow;
  wire pinReset;

  always @(posedge sys_clk) begin
    // internal power-on reset comes from nrst alone
    // RULE_14 power-on reset
    if (!nrst) begin
      csSync_reg <= 2'h3;
      sckSync_reg <= 2'h0;
      siSync_reg <= 2'h0;
      wpSync_reg <= 2'h3;
      rstSync_reg <= 2'h3;
      sckPrev_reg <= 1'b0;
      csPrev_reg <= 1'b1;
    end else begin
      // sck and si pass equal depths so each sampled bit lines up with its edge
      csSync_reg <= {csSync_reg[0], csN};
      sckSync_reg <= {sckSync_reg[0], sck};
      siSync_reg <= {siSync_reg[0], si};
      // RULE_11 floating protect reads high
      wpSync_reg <= {wpSync_reg[0], wpN | ~wpNConnected};
      rstSync_reg <= {rstSync_reg[0], resetPinN};
      sckPrev_reg <= sckSync_reg[1];
      csPrev_reg <= csSync_reg[1];
    end
  end

  assign csHigh = csSync_reg[1];
  assign siBit = siSync_reg[1];
  assign wpLow = ~wpSync_reg[1];
  assign pinReset = ~rstSync_reg[1];
  assign sckRise = sckSync_reg[1] && !sckPrev_reg;
  assign sckFall = !sckSync_reg[1] && sckPrev_reg;
  assign csFall = !csHigh && csPrev_reg;

////////////////////////////////////////////////////////////////////////////////
// frame state machine

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] bitCnt_reg;
  reg [1:0] byteCnt_reg;
  reg [7:0] shiftIn_reg;
  reg [7:0] txShift_reg;
  reg isRead_reg;
  reg mapFirst_reg;
  reg busyHold_reg;
  wire [7:0] byteNow;
  wire byteDone;
  wire [2:0] sectorIdx;
  wire [`SFPI_ADDR_BITS-1:0] addrNow;
  wire sectorGuarded;
  wire fifoReady;
  wire isProg;
  wire isErase;

  // RULE_17 msb first shift in
  assign byteNow = {shiftIn_reg[6:0], siBit};
  assign byteDone = sckRise && (bitCnt_reg == 3'h7);
  // sector from this frame's bytes, cmdAddr's top byte still holds the last frame's low byte
  assign addrNow = {cmdAddr[`SFPI_ADDR_BITS-9:0], byteNow};
  assign sectorIdx = addrNow[`SFPI_SECTOR_MSB:`SFPI_SECTOR_LSB];
  // RULE_07 protect pin forces the map on
  assign sectorGuarded = protMap[sectorIdx] && (protEnabled || wpLow);
  // only program and erase are discarded under write protect
  assign isProg = (cmdOpcode == `SFPI_OP_PROGRAM);
  assign isErase = (cmdOpcode == `SFPI_OP_ERASE);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `SFPI_ST_IDLE: begin
        // RULE_03 frames open on falling select
        if (csFall) begin
          state_next = `SFPI_ST_OPCODE;
        end
      end
      `SFPI_ST_OPCODE: begin
        // RULE_16 opcode byte comes first
        if (byteDone) begin
          state_next = `SFPI_ST_ADDR;
        end
      end
      `SFPI_ST_ADDR: begin
        if (byteDone && byteCnt_reg == 2'h2) begin
          // RULE_09 protected writes dropped
          if ((isProg || isErase) && (wpLow || sectorGuarded)) begin
            state_next = `SFPI_ST_DISCARD;
          end else begin
            state_next = `SFPI_ST_DATA;
          end
        end
      end
      `SFPI_ST_DATA: begin
        state_next = `SFPI_ST_DATA;
      end
      `SFPI_ST_DISCARD: begin
        state_next = `SFPI_ST_DISCARD;
      end
      default: begin
        state_next = `SFPI_ST_IDLE;
      end
    endcase
    // RULE_03 any frame ends on rising select
    if (csHigh) begin
      state_next = `SFPI_ST_IDLE;
    end
  end

  always @(posedge sys_clk) begin
    // RULE_12 pin reset aborts the frame
    // RULE_13 held as long as pin is low
    if (!nrst || pinReset) begin
      state_reg <= `SFPI_ST_IDLE;
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 2'h0;
      shiftIn_reg <= 8'h00;
      cmdOpcode <= 8'h00;
      cmdAddr <= {`SFPI_ADDR_BITS{1'b0}};
      cmdValid <= 1'b0;
      cmdDiscarded <= 1'b0;
      lockReq <= 1'b0;
      isRead_reg <= 1'b0;
      mapFirst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmdValid <= 1'b0;
      cmdDiscarded <= 1'b0;
      lockReq <= 1'b0;
      // a partial byte left at deselect is dropped with the counters
      if (csFall || csHigh) begin
        bitCnt_reg <= 3'h0;
        byteCnt_reg <= 2'h0;
        mapFirst_reg <= 1'b1;
      end else if (sckRise && state_reg != `SFPI_ST_IDLE) begin
        // RULE_05 sample on rising serial clock
        // RULE_02 only while selected
        shiftIn_reg <= byteNow;
        bitCnt_reg <= bitCnt_reg + 3'h1;
      end
      if (byteDone && state_reg == `SFPI_ST_OPCODE) begin
        cmdOpcode <= byteNow;
        isRead_reg <= (byteNow == `SFPI_OP_READ);
        // RULE_10 lock taken regardless of protect
        // lock is only a pulse, the core keeps the lock state
        if (byteNow == `SFPI_OP_LOCK) begin
          lockReq <= 1'b1;
        end
      end
      if (byteDone && state_reg == `SFPI_ST_ADDR) begin
        cmdAddr <= {cmdAddr[`SFPI_ADDR_BITS-9:0], byteNow};
        byteCnt_reg <= byteCnt_reg + 2'h1;
      end
      if (state_reg == `SFPI_ST_ADDR && state_next == `SFPI_ST_DATA) begin
        cmdValid <= 1'b1;
      end
      if (state_reg == `SFPI_ST_ADDR && state_next == `SFPI_ST_DISCARD) begin
        cmdDiscarded <= 1'b1;
      end
      if (byteDone && state_reg == `SFPI_ST_DATA) begin
        mapFirst_reg <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// protection state

  // protection survives the reset pin, only power-on clears it
  always @(posedge sys_clk) begin
    if (!nrst) begin
      protEnabled <= 1'b0;
      protMap <= `SFPI_MAP_RESET;
    end else if (!pinReset && !csHigh) begin
      // RULE_10 enable accepted under protect
      if (byteDone && state_reg == `SFPI_ST_OPCODE) begin
        if (byteNow == `SFPI_OP_PROT_ENABLE) begin
          protEnabled <= 1'b1;
        end else if (byteNow == `SFPI_OP_PROT_DISABLE) begin
          protEnabled <= 1'b0;
        end
      end
      // RULE_08 map frozen while protect is low
      if (!wpLow && byteDone && state_reg == `SFPI_ST_DATA && mapFirst_reg) begin
        if (cmdOpcode == `SFPI_OP_MAP_WRITE) begin
          protMap <= byteNow[SECTORS-1:0];
        end
      end
      if (!wpLow && state_reg == `SFPI_ST_ADDR && state_next == `SFPI_ST_DATA) begin
        if (cmdOpcode == `SFPI_OP_MAP_ERASE) begin
          protMap <= {SECTORS{1'b0}};
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// serial output

  always @(posedge sys_clk) begin
    if (!nrst || pinReset || csHigh) begin
      // RULE_01 deselected output is released
      soOut <= 1'b0;
      soOe <= 1'b0;
      txShift_reg <= 8'h00;
      txTaken <= 1'b0;
    end else begin
      txTaken <= 1'b0;
      // first byte loaded as the address ends, ahead of the first falling edge
      if (state_reg == `SFPI_ST_ADDR && state_next == `SFPI_ST_DATA && isRead_reg) begin
        txShift_reg <= txData;
        txTaken <= 1'b1;
        soOe <= 1'b1;
      end else if (sckFall && state_reg == `SFPI_ST_DATA && isRead_reg) begin
        // RULE_06 drive on falling serial clock
        // RULE_17 msb first shift out
        soOut <= txShift_reg[7];
        txShift_reg <= {txShift_reg[6:0], 1'b0};
      end
      // next byte taken once the last bit of this one is sampled
      if (byteDone && state_reg == `SFPI_ST_DATA && isRead_reg) begin
        txShift_reg <= txData;
        txTaken <= 1'b1;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// standby and write data path

  always @(posedge sys_clk) begin
    if (!nrst) begin
      standby <= 1'b1;
      busyHold_reg <= 1'b0;
    end else begin
      // extra cycle covers a busy flag that drops as select rises
      busyHold_reg <= coreBusy;
      // RULE_04 standby waits for the self-timed cycle
      // RULE_01 standby, never deep power-down
      standby <= csHigh && !coreBusy && !busyHold_reg;
    end
  end

  wire pushByte;
  assign pushByte = byteDone && state_reg == `SFPI_ST_DATA && !isRead_reg && !csHigh;

  // the link cannot be stalled, so a full fifo drops the byte and flags it
  always @(posedge sys_clk) begin
    if (!nrst || csFall) begin
      rxOverrun <= 1'b0;
    end else if (pushByte && !fifoReady) begin
      rxOverrun <= 1'b1;
    end
  end

  // the reset pin flushes queued write data along with the frame
  sfpi_fifo #(
    .WIDTH(`SFPI_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) rxFifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .flush(pinReset),
    .inValid(pushByte),
    .inReady(fifoReady),
    .inData(byteNow),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );
endmodule
`default_nettype wire

// ==== sfpi_device_sva.sv ====
// assertions on the device-side serial flash pin interface ports
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_defines.vh"
module sfpi_device_sva #(
  parameter SECTORS = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic soOe,
  input wire logic wpN,
  input wire logic wpNConnected,
  input wire logic resetPinN,
  input wire logic coreBusy,
  input wire logic standby,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic cmdDiscarded,
  input wire logic [SECTORS-1:0] protMap,
  input wire logic txTaken
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  chk_cs_tristate: assert property (csN [*4] |-> !soOe)
    else $error("serial out driven while deselected");
  chk_standby_idle: assert property ((csN && !coreBusy) [*6] |-> standby)
    else $error("no standby while deselected and idle");
  chk_busy_hold: assert property (coreBusy [*3] |-> !standby)
    else $error("standby entered during self-timed operation");
  chk_deselect_ignore: assert property (csN [*6] |-> !cmdValid && !cmdDiscarded && !txTaken)
    else $error("activity while deselected");
  chk_wp_discard: assert property (cmdValid && (cmdOpcode == `SFPI_OP_PROGRAM ||
    cmdOpcode == `SFPI_OP_ERASE) |-> wpN || !wpNConnected)
    else $error("program or erase accepted under write protect");
  chk_map_frozen: assert property ((wpNConnected && !wpN) [*4] |=> $stable(protMap))
    else $error("protection map changed under write protect");
  chk_reset_pin_idle: assert property (!resetPinN [*4] |-> !soOe && !cmdValid && !txTaken)
    else $error("activity while reset pin low");
  chk_opcode_first: assert property ($fell(csN) |-> !cmdValid [*8])
    else $error("command before opcode and address");
endmodule
bind sfpi_device sfpi_device_sva #(.SECTORS(SECTORS)) u_sva (.sys_clk, .nrst, .csN, .soOe, .wpN,
  .wpNConnected, .resetPinN, .coreBusy, .standby, .cmdValid, .cmdOpcode, .cmdDiscarded,
  .protMap, .txTaken);
`default_nettype wire

// ==== sfpi_fifo.v ====
// synchronous fifo with registered output stage
`timescale 1ns/1ns
`default_nettype none
module sfpi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire nrst,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doWrite;
  wire doRead;

  // output stage counts toward capacity, keeping the total at DEPTH words
  assign inReady = ((count_reg + {{AW{1'b0}}, outValid}) != DEPTH[AW:0]);
  assign doWrite = inValid && inReady;
  // refill the output stage whenever it is empty or being taken
  assign doRead = (count_reg != {(AW+1){1'b0}}) && (!outValid || outReady);

  always @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst || flush) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
        outData <= mem[rdPtr_reg];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sfpi_host_model.sv ====
// host controller model driving the serial link
`timescale 1ns/1ns
`default_nettype none
module sfpi_host_model (
  input wire logic sys_clk,
  output var logic csN,
  output var logic sck,
  output var logic si,
  input wire logic soOut,
  input wire logic soOe
);
  // 160 ns link clock, four system cycles each phase
  localparam int HALF = 4;
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic sel();
    @(posedge sys_clk) csN <= 1'b0;
    waitCyc(HALF);
  endtask
  task automatic desel();
    waitCyc(HALF);
    @(posedge sys_clk) begin
      csN <= 1'b1;
      si <= ~si;
    end
    waitCyc(HALF);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk) begin
        si <= tx[i];
        sck <= 1'b0;
      end
      waitCyc(HALF - 1);
      @(posedge sys_clk) sck <= 1'b1;
      waitCyc(HALF - 1);
      // released pin shows the inverse, never a stale bit
      rx[i] = soOe ? soOut : ~soOut;
    end
    @(posedge sys_clk) sck <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the device-side serial flash pin interface
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_defines.vh"
module testbench;
  typedef struct {logic wp; logic conn; logic [7:0] op; logic expV; logic expD;} sfpi_row_t;
  logic sys_clk, nrst, wpN, wpNConnected, resetPinN, coreBusy, rxReady;
  logic [7:0] txData, rx;
  wire logic csN, sck, si, soOut, soOe, standby, cmdValid, cmdDiscarded, lockReq;
  wire logic protEnabled, txTaken, rxValid, rxOverrun;
  wire logic [7:0] cmdOpcode, protMap, rxData;
  wire logic [23:0] cmdAddr;
  int err_total, comparisons, nValid, nDisc, nLock, nTaken, v0, d0, t0, n;
  sfpi_row_t rows [5];
  sfpi_device DUT (.sys_clk, .nrst, .csN, .sck, .si, .soOut, .soOe, .wpN, .wpNConnected,
    .resetPinN, .coreBusy, .standby, .cmdValid, .cmdOpcode, .cmdAddr, .cmdDiscarded, .lockReq,
    .protEnabled, .protMap, .txData, .txTaken, .rxValid, .rxReady, .rxData, .rxOverrun);
  sfpi_host_model host (.sys_clk, .csN, .sck, .si, .soOut, .soOe);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cmdValid === 1'b1) nValid <= nValid + 1;
    if (cmdDiscarded === 1'b1) nDisc <= nDisc + 1;
    if (lockReq === 1'b1) nLock <= nLock + 1;
    if (txTaken === 1'b1) nTaken <= nTaken + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmdFrame(input logic [7:0] op, input logic [23:0] addr, input int nData,
    input logic [7:0] base);
    logic [7:0] dummy;
    host.sel();
    host.xfer(op, dummy);
    for (int k = 2; k >= 0; k--) host.xfer(addr[k*8 +: 8], dummy);
    for (int k = 0; k < nData; k++) host.xfer(base + 8'(k), dummy);
    host.desel();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    wpN = 1'b1;
    wpNConnected = 1'b1;
    resetPinN = 1'b1;
    coreBusy = 1'b0;
    rxReady = 1'b1;
    txData = 8'h3C;
    rows = '{'{1, 1, `SFPI_OP_PROGRAM, 1, 0}, '{1, 1, `SFPI_OP_ERASE, 1, 0},
      '{0, 1, `SFPI_OP_PROGRAM, 0, 1}, '{0, 1, `SFPI_OP_ERASE, 0, 1},
      '{0, 0, `SFPI_OP_PROGRAM, 1, 0}};
    repeat (20) @(posedge sys_clk);
    check(standby, 1'b1);
    check(protMap, 8'h00);
    @(posedge sys_clk) nrst <= 1'b1;
    host.waitCyc(4);
    foreach (rows[r]) begin
      @(posedge sys_clk) begin
        wpN <= rows[r].wp;
        wpNConnected <= rows[r].conn;
      end
      v0 = nValid;
      d0 = nDisc;
      cmdFrame(rows[r].op, {rows[r].op, 16'h5AC3}, 0, 8'h00);
      check(nValid - v0, rows[r].expV);
      check(nDisc - d0, rows[r].expD);
      check(cmdOpcode, rows[r].op);
      if (rows[r].expV) check(cmdAddr, {rows[r].op, 16'h5AC3});
    end
    @(posedge sys_clk) begin
      wpN <= 1'b1;
      wpNConnected <= 1'b1;
    end
    cmdFrame(`SFPI_OP_MAP_WRITE, 24'h0, 1, 8'h81);
    check(protMap, 8'h81);
    @(posedge sys_clk) wpN <= 1'b0;
    cmdFrame(`SFPI_OP_MAP_WRITE, 24'h0, 1, 8'h18);
    cmdFrame(`SFPI_OP_MAP_ERASE, 24'h0, 0, 8'h00);
    check(protMap, 8'h81);
    v0 = nLock;
    cmdFrame(`SFPI_OP_PROT_ENABLE, 24'h0, 0, 8'h00);
    cmdFrame(`SFPI_OP_LOCK, 24'h0, 0, 8'h00);
    check(protEnabled, 1'b1);
    check(nLock - v0, 1);
    // read, then abort it with the reset pin
    @(posedge sys_clk) wpN <= 1'b1;
    t0 = nTaken;
    host.sel();
    host.xfer(`SFPI_OP_READ, rx);
    repeat (3) host.xfer(8'h00, rx);
    host.xfer(8'h00, rx);
    check(rx, 8'h3C);
    @(posedge sys_clk) resetPinN <= 1'b0;
    host.waitCyc(5);
    check(soOe, 1'b0);
    check(nTaken - t0, 2);
    v0 = nValid;
    repeat (4) host.xfer(`SFPI_OP_PROGRAM, rx);
    @(posedge sys_clk) resetPinN <= 1'b1;
    host.desel();
    check(nValid - v0, 0);
    check(soOe, 1'b0);
    repeat (4) host.xfer(`SFPI_OP_PROGRAM, rx);
    check(nValid - v0, 0);
    @(posedge sys_clk) coreBusy <= 1'b1;
    host.waitCyc(8);
    check(standby, 1'b0);
    @(posedge sys_clk) coreBusy <= 1'b0;
    host.waitCyc(8);
    check(standby, 1'b1);
    // guarded sector refused only while software protection is on
    v0 = nValid;
    d0 = nDisc;
    cmdFrame(`SFPI_OP_PROGRAM, 24'hE00000, 0, 8'h00);
    check(nDisc - d0, 1);
    cmdFrame(`SFPI_OP_PROT_DISABLE, 24'h0, 0, 8'h00);
    check(protEnabled, 1'b0);
    cmdFrame(`SFPI_OP_PROGRAM, 24'hE00000, 0, 8'h00);
    check(nValid - v0, 2);
    cmdFrame(`SFPI_OP_MAP_ERASE, 24'h0, 0, 8'h00);
    check(protMap, 8'h00);
    // fill past capacity with the reader stalled
    @(posedge sys_clk) rxReady <= 1'b0;
    cmdFrame(`SFPI_OP_PROGRAM, 24'h200000, 18, 8'h40);
    check(rxOverrun, 1'b1);
    @(posedge sys_clk) rxReady <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      if (rxValid === 1'b1) begin
        check(rxData, 8'h40 + 8'(n));
        n++;
      end
    end
    check(n, 16);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
